// File: watchdog_power_state_ctrl_tb.sv
// Self-checking bench for the power-state and watchdog supervisor
`timescale 1ns/100ps

module watchdog_power_state_ctrl_tb;
    import wps_pkg::*;
    localparam int          TICK  = 4;
    localparam int          LIMIT = 20000;
    localparam logic [17:0] A_ID  = 18'h00000;
    localparam logic [17:0] A_PS  = 18'h1000c;
    localparam logic [17:0] A_WD  = 18'h10010;
    localparam logic [17:0] A_ST  = 18'h10040;
    localparam logic [17:0] A_MK  = 18'h10044;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        key_unlocked_i = 1'b0;
    logic        on_event_i = 1'b0;
    logic        hw_kick_i = 1'b0;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
    logic [17:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        system_on_o, system_sleep_flag_o, lowpower_reference_sel_o;
    logic        soft_reset_o, device_reset_o;
    int          fails = 0, num_checks = 0, cyc_n = 0, sr_at = 0, dr_at = 0;

    always #10 clk_i = ~clk_i;

    wps_supervisor #(.TICK_CYCLES(TICK), .IDENT_CODE(16'h5a3c)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .key_unlocked_i(key_unlocked_i), .on_event_i(on_event_i),
        .hw_kick_i(hw_kick_i), .system_on_o(system_on_o),
        .system_sleep_flag_o(system_sleep_flag_o),
        .lowpower_reference_sel_o(lowpower_reference_sel_o),
        .soft_reset_o(soft_reset_o), .device_reset_o(device_reset_o), .irq_o(irq_o));

    wps_host host (
        .clk_i(clk_i), .ack_i(wb_ack_o), .dat_i(wb_dat_o), .cyc_o(wb_cyc_i),
        .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i),
        .dat_o(wb_dat_i));

    // Cycle count, pulse time stamps and hang guard
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (soft_reset_o === 1'b1) sr_at <= cyc_n;
        if (device_reset_o === 1'b1) dr_at <= cyc_n;
        if (cyc_n == LIMIT) begin
            fails++;
            finish_test();
        end
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Value is taken at the call, cycles after the write it follows has settled
    task automatic chk1(input logic got, input logic exp);
        @(negedge clk_i);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [17:0] a, input logic [15:0] d);
        logic [31:0] q;
        host.xfer(1'b1, a, {16'h0, d}, q);
    endtask

    task automatic rd(input logic [17:0] a, output logic [31:0] q);
        host.xfer(1'b0, a, 32'h0, q);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic mark(output int t);
        @(negedge clk_i);
        t = cyc_n;
        @(posedge clk_i);
    endtask

    task automatic t_reset;
        logic [31:0] q;
        rd(A_ID, q); chk(q, 32'h5a3c);
        rd(A_PS, q); chk(q, 32'h0800);
        rd(A_WD, q); chk(q, 32'ha217);
        rd(18'h00100, q); chk(q, 32'h0);
        chk1(system_on_o, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_power;
        logic [31:0] q;
        wr(A_PS, 16'h8800); idle(15); chk1(system_on_o, 1'b0);
        on_event_i <= 1'b1;
        @(posedge clk_i);
        on_event_i <= 1'b0;
        idle(2); chk1(system_on_o, 1'b0);
        idle(8); chk1(system_on_o, 1'b1);
        wr(A_PS, 16'hc000); chk1(system_sleep_flag_o, 1'b1);
        wr(A_PS, 16'h8000); chk1(system_sleep_flag_o, 1'b0);
        wr(A_PS, 16'hcc00); chk1(system_sleep_flag_o, 1'b0);
        idle(45); chk1(system_sleep_flag_o, 1'b1);
        wr(A_PS, 16'hd000); chk1(lowpower_reference_sel_o, 1'b1);
        chk1(system_sleep_flag_o, 1'b1);
        wr(A_PS, 16'h9000); chk1(system_sleep_flag_o, 1'b0);
        rd(A_PS, q); chk(q, 32'h9000);
        wr(A_PS, 16'h1000); chk1(system_on_o, 1'b0);
        rd(A_ST, q); chk(q & 32'h4, 32'h4);
        $display("test power done");
    endtask

    task automatic t_sreset;
        int t0;
        wr(A_ID, 16'h0000); mark(t0);
        chk1((t0 - sr_at) <= 4, 1'b1);
        wr(A_PS, 16'h0a00); wr(A_ID, 16'h0000); mark(t0);
        idle(12); chk1(sr_at > t0 && sr_at <= t0 + 8, 1'b1);
        $display("test soft reset done");
    endtask

    task automatic t_wdog;
        logic [31:0] q;
        int tk;
        key_unlocked_i <= 1'b1;
        wr(A_ST, 16'h0007); wr(A_MK, 16'h0000); wr(A_WD, 16'haa10);
        idle(900); wr(A_WD, 16'haa10); mark(tk);
        idle(880); rd(A_ST, q); chk(q & 32'h1, 32'h0);
        idle(200); rd(A_ST, q); chk(q & 32'h1, 32'h1);
        chk1(irq_o, 1'b0);
        wr(A_MK, 16'h0001); chk1(irq_o, 1'b1);
        wr(A_ST, 16'h0001); chk1(irq_o, 1'b0);
        idle(1000); chk1(dr_at - tk >= 2030 && dr_at - tk <= 2060, 1'b1);
        wr(A_ST, 16'h0007); wr(A_WD, 16'hea10);
        idle(1300); rd(A_ST, q); chk(q & 32'h1, 32'h0);
        // Hardware kicks only
        wr(A_ST, 16'h0007); wr(A_WD, 16'h8210);
        repeat (6) begin
            idle(200);
            hw_kick_i <= 1'b1;
            idle(3);
            hw_kick_i <= 1'b0;
        end
        rd(A_ST, q); chk(q & 32'h1, 32'h0);
        idle(900); wr(A_WD, 16'h8a10);
        idle(300); rd(A_ST, q); chk(q & 32'h1, 32'h1);
        // Disabled watchdog must not reach its secondary stage
        wr(A_ST, 16'h0007); wr(A_WD, 16'h2110);
        idle(1100); rd(A_ST, q); chk(q & 32'h3, 32'h0);
        wr(A_WD, 16'ha210);
        key_unlocked_i <= 1'b0;
        wr(A_WD, 16'h0000); rd(A_WD, q); chk(q, 32'ha210);
        $display("test watchdog done");
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_power();
        t_sreset();
        t_wdog();
        finish_test();
    end
endmodule

// File: wps_host.sv
// Host processor model: classic Wishbone master for register access
`timescale 1ns/100ps

module wps_host (
    // Clock
    input  wire logic        clk_i,
    // Slave answer
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    // Master request
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic      [17:0] adr_o,
    output logic      [3:0]  sel_o,
    output logic      [31:0] dat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 18'h0;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // Request held until ack sampled, then one idle cycle
    task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        sel_o <= 4'h3;
        dat_o <= d;
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule

// File: wps_pkg.sv
// Constants and types shared by the power-state and watchdog supervisor
package wps_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_IDENT    = 16'h0000;
    localparam logic [15:0] IDX_POWER    = 16'h4003;
    localparam logic [15:0] IDX_WDOG     = 16'h4004;
    localparam logic [15:0] IDX_IRQ_STAT = 16'h4010;
    localparam logic [15:0] IDX_IRQ_MASK = 16'h4011;

    // Power state register fields
    localparam int PS_ON_BIT    = 15;
    localparam int PS_SLP_BIT   = 14;
    localparam int PS_REF_BIT   = 12;
    localparam int PS_DLY_LSB   = 10;
    localparam int PS_DEFER_BIT = 9;

    // Watchdog register fields
    localparam int WD_ENA_BIT   = 15;
    localparam int WD_PAUSE_BIT = 14;
    localparam int WD_SRC_BIT   = 13;
    localparam int WD_SLP_BIT   = 12;
    localparam int WD_KICK_BIT  = 11;
    localparam int WD_SEC_LSB   = 8;
    localparam int WD_PRIM_LSB  = 4;
    localparam int WD_TO_LSB    = 0;

    // Reset values
    localparam logic [1:0] RST_DLY_SEL  = 2'h2;
    localparam logic       RST_DEFER    = 1'b0;
    localparam logic       RST_LOWPOWER_REFERENCE_SEL   = 1'b0;
    localparam logic       RST_WD_ENA   = 1'b1;
    localparam logic       RST_WD_PAUSE = 1'b0;
    localparam logic       RST_WD_SRC   = 1'b1;
    localparam logic       RST_WD_SLP   = 1'b0;
    localparam logic [1:0] RST_WD_SEC   = 2'h2;
    localparam logic [1:0] RST_WD_PRIM  = 2'h1;
    localparam logic [2:0] RST_WD_TO    = 3'h7;
    localparam logic [2:0] RST_IRQ_MASK = 3'h0;

    // Delay select codes
    localparam logic [1:0] DLY_SEL_1MS  = 2'h2;
    localparam logic [1:0] DLY_SEL_10MS = 2'h3;

    // Timeout action codes
    typedef enum logic [1:0] {
        ACT_NONE  = 2'h0,
        ACT_IRQ   = 2'h1,
        ACT_RESET = 2'h2,
        ACT_WAKE  = 2'h3
    } wps_action_t;

    // Power state machine, one-hot
    typedef enum logic [3:0] {
        ST_OFF   = 4'h1,
        ST_ON    = 4'h2,
        ST_SLEEP = 4'h4,
        ST_DELAY = 4'h8
    } wps_state_t;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_SHORT_MS  = 1;
    localparam int DLY_LONG_MS   = 10;
    localparam int WD_BASE_MS    = 256;

    // Interrupt status bits
    localparam int IRQ_PRIM_BIT  = 0;
    localparam int IRQ_SEC_BIT   = 1;
    localparam int IRQ_STATE_BIT = 2;

endpackage

// File: wps_supervisor.sv
// Power-state control and watchdog supervisor with Wishbone register slave
//
// Behaviour
// - System-on status bit 15 reads 0 in OFF, 1 in ON or SLEEP.
// - Writing 0 to system-on bit starts a transition to OFF.
// - Writing 1 to system-on bit never starts an ON transition.
// - Sleep status bit 14 reads 1 in SLEEP and while a transition out of SLEEP is pending.
// - Writing 0 to sleep bit wakes the system out of SLEEP.
// - Writing 1 to sleep bit puts the system into SLEEP.
// - Bit 12 selects low-power reference; host sets it only with converter off.
// - Bits 11:10 set transition delay: none, none, 1 ms, 10 ms.
// - Bit 9 set postpones a software reset by the transition delay.
// - Watchdog enable bit 15, default set, does not restart the count.
// - Pause bit 14 freezes the watchdog count while set.
// - Bit 13 picks kick source; software kick bit 11 works only when set.
// - In SLEEP the watchdog stops unless sleep gate bit 12 is set.
// - Action codes: none, interrupt, device reset, WAKE; primary defaults interrupt.
// - Secondary action fires after two unkicked periods of 0.256 s doubling.
// - Watchdog configuration fields change only while the key is unlocked.
// - Any write to the identity register issues a software reset command.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/100ps

module wps_supervisor
    import wps_pkg::*;
#(
    parameter int          TICK_CYCLES = MS_CYCLES,
    parameter logic [15:0] IDENT_CODE  = 16'h5a3c  // Arbitrary value
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [17:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // System inputs
    input  wire logic        key_unlocked_i,
    input  wire logic        on_event_i,
    input  wire logic        hw_kick_i,
    // Status and commands
    output logic             system_on_o,
    output logic             system_sleep_flag_o,
    output logic             lowpower_reference_sel_o,
    output logic             soft_reset_o,
    output logic             device_reset_o,
    output logic             irq_o
);

    localparam logic [23:0] TICK_LIM  = 24'(TICK_CYCLES - 1);
    localparam logic [23:0] DLY_S_CYC = 24'(DLY_SHORT_MS * TICK_CYCLES);
    localparam logic [23:0] DLY_L_CYC = 24'(DLY_LONG_MS * TICK_CYCLES);

    wps_state_t  state;
    wps_state_t  next_state;
    wps_state_t  tgt;
    wps_state_t  next_tgt;
    logic [15:0] idx;
    logic        acc;
    logic        wr_stb;
    logic        ps_wr;
    logic        wd_wr_hi;
    logic        wd_wr_lo;
    logic [1:0]  transition_delay_sel;
    logic        soft_reset_defer;
    logic        dly_zero;
    logic [1:0]  eff_dly_sel;
    logic [23:0] dly_hold;
    logic [23:0] dly_lim;
    logic [23:0] dly_cnt;
    logic        dly_done;
    logic        srst_pend;
    logic [23:0] srst_cnt;
    logic        supervisor_enable;
    logic        supervisor_pause;
    logic        kick_source_sel;
    logic        supervisor_sleep_gate;
    logic [1:0]  second_stage_action;
    logic [1:0]  first_stage_action;
    logic [2:0]  timeout_period_sel;
    logic [23:0] tick_cnt;
    logic        tick;
    logic [15:0] wd_cnt;
    logic [15:0] wd_lim;
    logic        stage;
    logic        run;
    logic        kick;
    logic        timeout;
    logic [1:0]  act;
    logic        hk_s1;
    logic        hk_s2;
    logic        hk_s3;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic [2:0]  next_irq_stat;
    logic [15:0] rd_val;

    // Bus decode
    assign idx      = wb_adr_i[17:2];
    assign acc      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_stb   = acc && wb_we_i;
    assign ps_wr    = wr_stb && (idx == IDX_POWER) && wb_sel_i[1];
    assign wd_wr_hi = wr_stb && (idx == IDX_WDOG) && wb_sel_i[1];
    assign wd_wr_lo = wr_stb && (idx == IDX_WDOG) && wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= acc;
        end
    end

    // Read mux; unmapped reads give zero
    always_comb begin
        rd_val = 16'h0000;
        case (idx)
            IDX_IDENT:    rd_val = IDENT_CODE;
            IDX_POWER:    rd_val = {system_on_o, system_sleep_flag_o, 1'b0,
                                    lowpower_reference_sel_o, transition_delay_sel,
                                    soft_reset_defer, 9'h000};
            // Kick bit reads back as zero
            IDX_WDOG:     rd_val = {supervisor_enable, supervisor_pause, kick_source_sel,
                                    supervisor_sleep_gate, 2'h0, second_stage_action,
                                    2'h0, first_stage_action, 1'b0, timeout_period_sel};
            IDX_IRQ_STAT: rd_val = {13'h0000, irq_stat};
            IDX_IRQ_MASK: rd_val = {13'h0000, irq_mask};
            default:      rd_val = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (acc && !wb_we_i) begin
            wb_dat_o <= {16'h0000, rd_val};
        end
    end

    // Power state register fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lowpower_reference_sel_o <= RST_LOWPOWER_REFERENCE_SEL;
            transition_delay_sel     <= RST_DLY_SEL;
            soft_reset_defer         <= RST_DEFER;
        end else if (ps_wr) begin
            lowpower_reference_sel_o <= wb_dat_i[PS_REF_BIT];
            transition_delay_sel     <= wb_dat_i[PS_DLY_LSB +: 2];
            soft_reset_defer         <= wb_dat_i[PS_DEFER_BIT];
        end
    end

    // A command uses the delay code written alongside it
    assign eff_dly_sel = ps_wr ? wb_dat_i[PS_DLY_LSB +: 2] : transition_delay_sel;

    always_comb begin
        case (eff_dly_sel)
            DLY_SEL_1MS:  dly_lim = DLY_S_CYC;
            DLY_SEL_10MS: dly_lim = DLY_L_CYC;
            default:      dly_lim = 24'h000000;
        endcase
    end
    assign dly_zero = (dly_lim == 24'h000000);
    assign dly_done = (state == ST_DELAY) && (dly_cnt == dly_hold - 24'h000001);

    // Power state transitions
    always_comb begin
        wps_state_t req;
        logic       go;
        req        = state;
        go         = 1'b0;
        next_state = state;
        next_tgt   = tgt;
        case (state)
            ST_OFF: begin
                // only an external ON event leaves OFF
                if (on_event_i) begin
                    req = ST_ON;
                    go  = 1'b1;
                end
            end
            ST_ON: begin
                if (ps_wr && !wb_dat_i[PS_ON_BIT]) begin
                    req = ST_OFF;
                    go  = 1'b1;
                end else if (ps_wr && wb_dat_i[PS_SLP_BIT]) begin
                    req = ST_SLEEP;
                    go  = 1'b1;
                end
            end
            ST_SLEEP: begin
                if (ps_wr && !wb_dat_i[PS_ON_BIT]) begin
                    req = ST_OFF;
                    go  = 1'b1;
                // WAKE by command or watchdog action
                end else if ((ps_wr && !wb_dat_i[PS_SLP_BIT]) ||
                             (timeout && act == ACT_WAKE)) begin
                    req = ST_ON;
                    go  = 1'b1;
                end
            end
            ST_DELAY: begin
                if (dly_done) begin
                    next_state = tgt;
                end
            end
            default: next_state = ST_OFF;
        endcase
        if (go) begin
            if (dly_zero) begin
                next_state = req;
            end else begin
                next_state = ST_DELAY;
                next_tgt   = req;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_OFF;
            tgt   <= ST_OFF;
        end else begin
            state <= next_state;
            tgt   <= next_tgt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || state != ST_DELAY) begin
            dly_cnt <= 24'h000000;
        end else begin
            dly_cnt <= dly_cnt + 24'h000001;
        end
    end

    // Length latched on entry; later field writes cannot strand the delay
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dly_hold <= 24'h000000;
        end else if (state != ST_DELAY) begin
            dly_hold <= dly_lim;
        end
    end

    // Status flags hold their value while a transition is pending
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            system_on_o         <= 1'b0;
            system_sleep_flag_o <= 1'b0;
        end else if (next_state != ST_DELAY) begin
            system_on_o         <= (next_state != ST_OFF);
            system_sleep_flag_o <= (next_state == ST_SLEEP);
        end
    end

    // identity write issues soft reset, may defer it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            srst_pend    <= 1'b0;
            srst_cnt     <= 24'h000000;
            soft_reset_o <= 1'b0;
        end else begin
            soft_reset_o <= 1'b0;
            if (wr_stb && idx == IDX_IDENT && wb_sel_i != 4'h0) begin
                if (soft_reset_defer && !dly_zero) begin
                    srst_pend <= 1'b1;
                    srst_cnt  <= 24'h000000;
                end else begin
                    soft_reset_o <= 1'b1;
                end
            end else if (srst_pend) begin
                if (dly_zero || srst_cnt >= dly_lim - 24'h000001) begin
                    srst_pend    <= 1'b0;
                    soft_reset_o <= 1'b1;
                end else begin
                    srst_cnt <= srst_cnt + 24'h000001;
                end
            end
        end
    end

    // watchdog fields writable only when unlocked
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            supervisor_enable     <= RST_WD_ENA;
            supervisor_pause      <= RST_WD_PAUSE;
            kick_source_sel       <= RST_WD_SRC;
            supervisor_sleep_gate <= RST_WD_SLP;
            second_stage_action   <= RST_WD_SEC;
        end else if (wd_wr_hi && key_unlocked_i) begin
            supervisor_enable     <= wb_dat_i[WD_ENA_BIT];
            supervisor_pause      <= wb_dat_i[WD_PAUSE_BIT];
            kick_source_sel       <= wb_dat_i[WD_SRC_BIT];
            supervisor_sleep_gate <= wb_dat_i[WD_SLP_BIT];
            second_stage_action   <= wb_dat_i[WD_SEC_LSB +: 2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_stage_action <= RST_WD_PRIM;
            timeout_period_sel <= RST_WD_TO;
        end else if (wd_wr_lo && key_unlocked_i) begin
            first_stage_action <= wb_dat_i[WD_PRIM_LSB +: 2];
            timeout_period_sel <= wb_dat_i[WD_TO_LSB +: 3];
        end
    end

    // Millisecond tick
    always_ff @(posedge clk_i) begin
        if (rst_i || tick) begin
            tick_cnt <= 24'h000000;
        end else begin
            tick_cnt <= tick_cnt + 24'h000001;
        end
    end
    assign tick = (tick_cnt == TICK_LIM);

    // Hardware kick synchroniser and rising edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hk_s1 <= 1'b0;
            hk_s2 <= 1'b0;
            hk_s3 <= 1'b0;
        end else begin
            hk_s1 <= hw_kick_i;
            hk_s2 <= hk_s1;
            hk_s3 <= hk_s2;
        end
    end

    assign kick = (!kick_source_sel && hk_s2 && !hk_s3) ||
                  (kick_source_sel && wd_wr_hi && wb_dat_i[WD_KICK_BIT]);
    // enable only, pause freezes, sleep gating
    assign run  = supervisor_enable && !supervisor_pause &&
                  (state != ST_SLEEP || supervisor_sleep_gate);
    // period doubles per code from base
    assign wd_lim  = 16'(WD_BASE_MS) << timeout_period_sel;
    assign timeout = run && tick && !kick && (wd_cnt == wd_lim - 16'h0001);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_cnt <= 16'h0000;
            stage  <= 1'b0;
        // valid kick clears count and stage
        end else if (kick) begin
            wd_cnt <= 16'h0000;
            stage  <= 1'b0;
        end else if (timeout) begin
            wd_cnt <= 16'h0000;
            stage  <= !stage;
        end else if (run && tick) begin
            wd_cnt <= wd_cnt + 16'h0001;
        end
    end

    // primary at first period, secondary at second
    always_comb begin
        act = ACT_NONE;
        if (timeout) begin
            act = stage ? second_stage_action : first_stage_action;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            device_reset_o <= 1'b0;
        end else begin
            device_reset_o <= timeout && (act == ACT_RESET);
        end
    end

    // Interrupts; set wins over write-one clear
    always_comb begin
        logic [2:0] set;
        logic [2:0] clr;
        set = 3'h0;
        clr = 3'h0;
        set[IRQ_PRIM_BIT]  = timeout && !stage && (act == ACT_IRQ);
        set[IRQ_SEC_BIT]   = timeout && stage && (act == ACT_IRQ);
        set[IRQ_STATE_BIT] = (next_state != state) && (next_state != ST_DELAY);
        if (wr_stb && idx == IDX_IRQ_STAT && wb_sel_i[0]) begin
            clr = wb_dat_i[2:0];
        end
        next_irq_stat = (irq_stat & ~clr) | set;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= 3'h0;
            irq_mask <= RST_IRQ_MASK;
            irq_o    <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            if (wr_stb && idx == IDX_IRQ_MASK && wb_sel_i[0]) begin
                irq_mask <= wb_dat_i[2:0];
                irq_o    <= |(next_irq_stat & wb_dat_i[2:0]);
            end else begin
                irq_o    <= |(next_irq_stat & irq_mask);
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_on_flag_state: assert property (
        state != ST_DELAY |-> system_on_o == (state != ST_OFF))
        else $error("system-on flag disagrees with state");
    a_off_command: assert property (
        state == ST_ON && ps_wr && !wb_dat_i[PS_ON_BIT]
        |=> state == ST_OFF || (state == ST_DELAY && tgt == ST_OFF))
        else $error("OFF command not followed");
    a_off_stays: assert property (
        state == ST_OFF && !on_event_i |=> state == ST_OFF)
        else $error("left OFF without ON event");
    a_sleep_flag: assert property (
        state == ST_SLEEP |-> system_sleep_flag_o && system_on_o)
        else $error("sleep flag low in SLEEP");
    a_sleep_command: assert property (
        state == ST_ON && ps_wr && wb_dat_i[PS_ON_BIT] && wb_dat_i[PS_SLP_BIT] && dly_zero
        |=> state == ST_SLEEP)
        else $error("SLEEP command not followed");
    a_delay_bound: assert property (
        state == ST_DELAY |-> dly_hold != 24'h000000 && dly_cnt < dly_hold)
        else $error("transition delay overran");
    a_srst_now: assert property (
        wr_stb && idx == IDX_IDENT && wb_sel_i != 4'h0 && !soft_reset_defer
        |=> soft_reset_o)
        else $error("undeferred soft reset missing");
    a_count_frozen: assert property (
        !run && !kick |=> wd_cnt == $past(wd_cnt) && stage == $past(stage))
        else $error("watchdog counted while stopped");
    a_kick_clears: assert property (
        kick |=> wd_cnt == 16'h0000 && !stage)
        else $error("kick did not clear watchdog");
    a_locked_write: assert property (
        wr_stb && !key_unlocked_i |=> $stable(supervisor_enable) &&
        $stable(timeout_period_sel) && $stable(first_stage_action))
        else $error("locked watchdog field changed");
    a_prim_irq: assert property (
        timeout && !stage && first_stage_action == ACT_IRQ |=> irq_stat[IRQ_PRIM_BIT])
        else $error("primary interrupt not raised");
    a_sec_reset: assert property (
        timeout && stage && second_stage_action == ACT_RESET |=> device_reset_o ##1 !stage)
        else $error("secondary reset not issued");

    c_sleep_entry: cover property (state == ST_ON ##1 state == ST_SLEEP);
    c_prim_timeout: cover property (timeout && !stage);
    c_sec_timeout: cover property (timeout && stage);
    c_soft_reset: cover property (srst_pend ##1 soft_reset_o);

endmodule
